// ---- rx_error_status.sv ----
// Purpose : Receive error enables, sticky status, packet capture and error count
// Assumes : Event inputs are one-cycle pulses synchronous to ref_clk
// Notes   : Avalon-MM slave with one wait state on every access
// Function
// - Enable A, reset all ones, gates eight lane errors onto combined error
// - Enable B, bits 6..0 reset set, bit 7 reserved, gates seven protocol errors
// - Checksum error is a mismatch of the 16-bit CRC trailing a long packet
// - Status bit 6 sets on cross-domain video FIFO overflow
// - Status read clears overflow flag unless an overflow arrives that cycle
// - Status bit 4 sets on link buffer overflow, clears on status read
// - Status bit 3 command FIFO overflow never sets
// - Status bit 1 read without turnaround stays zero
// - Status bit 2 sets on EOT without EOT packet when mode bit is 0
// - Status bit 0 sets on any enabled error, clears on status read
// - Count of detected error events readable from a count register
// - Capture bits 7-6 hold last pixel packet channel, reset zero, read-only
// - Capture bits 5-0 hold last pixel packet type code
// - Capture updates only when type low nibble lies in 0xB..0xE
// - Hold-error 1 latches combined error, 0 shows pulses
// - No-EOT-packet mode 0 reports missing EOT packet as an error
// - Channel not enabled in mask raises invalid channel error, no filtering
//
// Implementation choice: the Avalon-MM interface to the registers.
module rx_error_status #(
  parameter int COUNT_W = 8
) (
  input  wire logic                       ref_clk,
  input  wire logic                       sys_rst,
  input  wire logic [9:0]                 address,
  input  wire logic                       read,
  input  wire logic                       write,
  input  wire logic [31:0]                writedata,
  output logic      [31:0]                readdata,
  output logic                            waitrequest,
  input  wire rx_err_pkg::phy_errors_t    phy_errors,
  input  wire rx_err_pkg::proto_errors_t  proto_errors,
  input  wire rx_err_pkg::header_t        header,
  input  wire rx_err_pkg::crc_check_t     crc_check,
  input  wire rx_err_pkg::eot_event_t     eot_event,
  input  wire rx_err_pkg::buffer_events_t buffer_events,
  output logic                            rx_error,
  output logic                            irq
);
  import rx_err_pkg::*;

  // Sticky flag with set winning over clear
  function automatic logic [7:0] sticky(input logic [7:0] cur,
                                        input logic [7:0] set,
                                        input logic [7:0] clr);
    sticky = (cur & ~clr) | set;
  endfunction : sticky

  function automatic logic is_pixel_type(input logic [5:0] code);
    is_pixel_type = (code[3:0] >= PIXEL_TYPE_LOW) && (code[3:0] <= PIXEL_TYPE_HIGH);
  endfunction : is_pixel_type

  logic [3:0]         channel_enable_mask;
  logic               hold_error;
  logic               no_eot_packet_mode;
  logic [7:0]         error_enable_a;
  logic [6:0]         error_enable_b;
  logic [7:0]         status_flags;
  logic [COUNT_W-1:0] error_count;
  logic [1:0]         last_virtual_channel;
  logic [5:0]         last_packet_type;
  logic [7:0]         error_report_a;
  logic [7:0]         irq_status;
  logic [7:0]         irq_mask;
  logic               ack;
  logic               held_error;

  logic [7:0]  index;
  logic        wr_done;
  logic        rd_done;
  logic        status_read;
  logic        report_read;
  logic        invalid_channel;
  logic        checksum_error;
  logic        missing_eot;
  logic [6:0]  proto_vec;
  logic [7:0]  enabled_a;
  logic [6:0]  enabled_b;
  logic        enabled_any;
  logic [7:0]  status_set;
  logic [7:0]  report_set;
  logic [7:0]  irq_set;
  logic [7:0]  next_readdata;

  assign index       = address[9:2];
  assign waitrequest = (read | write) & ~ack;
  assign wr_done     = write & ack;
  assign rd_done     = read & ack;
  assign status_read = rd_done && (index == IDX_STATUS_FLAGS);
  assign report_read = rd_done && (index == IDX_ERR_REPORT_A);

  // Bus handshake: request seen at one edge, completed at the next
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ack <= 1'b0;
    end else begin
      ack <= (read | write) & ~ack;
    end
  end

  assign invalid_channel = header.valid & ~channel_enable_mask[header.channel];
  assign checksum_error  = crc_check.valid && (crc_check.received != crc_check.computed);
  assign missing_eot     = eot_event.valid & ~eot_event.packet_seen & ~no_eot_packet_mode;

  assign proto_vec = {proto_errors.eot_sync, proto_errors.protocol,
                      proto_errors.invalid_length, invalid_channel,
                      proto_errors.invalid_type, checksum_error,
                      proto_errors.multi_bit_ecc};

  assign enabled_a   = phy_errors & error_enable_a;
  assign enabled_b   = proto_vec & error_enable_b;
  assign enabled_any = (|enabled_a) | (|enabled_b);

  always_comb begin
    status_set = 8'h00;
    status_set[ST_FIFO_OVERFLOW]  = buffer_events.fifo_overflow;
    status_set[ST_FIFO_UNDERFLOW] = buffer_events.fifo_underflow;
    status_set[ST_LINK_BUFFER]    = buffer_events.link_buffer_overflow;
    status_set[ST_CMD_OVERFLOW]   = 1'b0;
    status_set[ST_MISSING_EOT]    = missing_eot;
    status_set[ST_READ_NO_TURN]   = 1'b0;
    status_set[ST_ERROR_DETECTED] = enabled_any;
  end

  // clear on read, simultaneous set wins
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      status_flags <= RST_ZERO;
    end else begin
      status_flags <= sticky(status_flags, status_set, {8{status_read}});
    end
  end

  // Report register mirrors enabled B bits 5..0 and enabled A bit 7 in its own layout; clears on its own read
  always_comb begin
    report_set    = 8'h00;
    report_set[7] = enabled_b[5];
    report_set[5] = enabled_b[4];
    report_set[4] = enabled_b[3];
    report_set[3] = enabled_b[2];
    report_set[2] = enabled_b[1];
    report_set[1] = enabled_b[0];
    report_set[0] = enabled_a[7];
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      error_report_a <= RST_ZERO;
    end else begin
      error_report_a <= sticky(error_report_a, report_set, {8{report_read}});
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      error_count <= '0;
    end else if (enabled_any && (error_count != {COUNT_W{1'b1}})) begin
      error_count <= error_count + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      last_virtual_channel <= 2'h0;
      last_packet_type     <= 6'h00;
    end else if (header.valid && is_pixel_type(header.packet_type_code)) begin
      last_virtual_channel <= header.channel;
      last_packet_type     <= header.packet_type_code;
    end
  end

  // held copy clears with the status read, new error still wins
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      held_error <= 1'b0;
    end else begin
      held_error <= (held_error & ~status_read) | enabled_any;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rx_error <= 1'b0;
    end else if (hold_error) begin
      rx_error <= (held_error & ~status_read) | enabled_any;
    end else begin
      rx_error <= enabled_any;
    end
  end

  // Configuration writes
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      channel_enable_mask <= RST_CHANNEL_MASK;
      hold_error          <= 1'b0;
      no_eot_packet_mode  <= 1'b0;
      error_enable_a      <= RST_ERR_ENABLE_A;
      error_enable_b      <= RST_ERR_ENABLE_B;
      irq_mask            <= RST_ZERO;
    end else if (wr_done) begin
      case (index)
        IDX_CHANNEL_CONFIG: begin
          channel_enable_mask <= writedata[3:0];
        end
        IDX_MODE_CONFIG: begin
          hold_error         <= writedata[MODE_HOLD_ERROR];
          no_eot_packet_mode <= writedata[MODE_NO_EOT_PACKET];
        end
        IDX_ERR_ENABLE_A: begin
          error_enable_a <= writedata[7:0];
        end
        IDX_ERR_ENABLE_B: begin
          error_enable_b <= writedata[6:0];
        end
        IDX_IRQ_MASK: begin
          irq_mask <= {3'h0, writedata[IRQ_BITS-1:0]};
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    irq_set = 8'h00;
    irq_set[IRQ_ERROR]          = enabled_any;
    irq_set[IRQ_MISSING_EOT]    = missing_eot;
    irq_set[IRQ_FIFO_OVERFLOW]  = buffer_events.fifo_overflow;
    irq_set[IRQ_FIFO_UNDERFLOW] = buffer_events.fifo_underflow;
    irq_set[IRQ_LINK_BUFFER]    = buffer_events.link_buffer_overflow;
  end

  // Write one to clear; an event in the same cycle keeps its bit
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_status <= RST_ZERO;
    end else begin
      irq_status <= sticky(irq_status, irq_set,
                           (wr_done && (index == IDX_IRQ_STATUS)) ? writedata[7:0] : 8'h00);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // Read mux; unmapped indices read zero
  always_comb begin
    case (index)
      IDX_CHANNEL_CONFIG: next_readdata = {4'h0, channel_enable_mask};
      IDX_MODE_CONFIG:    next_readdata = {3'h0, hold_error, 3'h0, no_eot_packet_mode};
      IDX_ERR_ENABLE_A:   next_readdata = error_enable_a;
      IDX_ERR_ENABLE_B:   next_readdata = {1'b0, error_enable_b};
      IDX_STATUS_FLAGS:   next_readdata = status_flags;
      IDX_ERROR_COUNT:    next_readdata = 8'(error_count);
      IDX_LAST_PACKET:    next_readdata = {last_virtual_channel, last_packet_type};
      IDX_ERR_REPORT_A:   next_readdata = error_report_a;
      IDX_IRQ_STATUS:     next_readdata = irq_status;
      IDX_IRQ_MASK:       next_readdata = irq_mask;
      default:            next_readdata = 8'h00;
    endcase
  end

  // Data is captured in the wait cycle so it stands at the completing edge
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      readdata <= 32'h00000000;
    end else if (read && !ack) begin
      readdata <= {24'h000000, next_readdata};
    end
  end

endmodule : rx_error_status

// ---- rx_err_pkg.sv ----
// Purpose : Shared constants and carriers for the receive error/status register bank
// Assumes : Register indices are word indices; byte address is four times the index
// Notes   : Field positions follow the register layouts of the bank
package rx_err_pkg;

  // Register word indices
  localparam logic [7:0] IDX_CHANNEL_CONFIG = 8'h20;
  localparam logic [7:0] IDX_MODE_CONFIG    = 8'h21;
  localparam logic [7:0] IDX_ERR_ENABLE_A   = 8'h22;
  localparam logic [7:0] IDX_ERR_ENABLE_B   = 8'h23;
  localparam logic [7:0] IDX_STATUS_FLAGS   = 8'h28;
  localparam logic [7:0] IDX_ERROR_COUNT    = 8'h29;
  localparam logic [7:0] IDX_LAST_PACKET    = 8'h2A;
  localparam logic [7:0] IDX_ERR_REPORT_A   = 8'h2B;
  localparam logic [7:0] IDX_IRQ_STATUS     = 8'h40;
  localparam logic [7:0] IDX_IRQ_MASK       = 8'h41;

  // Reset values
  localparam logic [7:0] RST_ERR_ENABLE_A   = 8'hFF;
  localparam logic [6:0] RST_ERR_ENABLE_B   = 7'h7F;
  localparam logic [3:0] RST_CHANNEL_MASK   = 4'hF;
  localparam logic [7:0] RST_ZERO           = 8'h00;

  // Status flag bit positions
  localparam int ST_FIFO_OVERFLOW   = 6;
  localparam int ST_FIFO_UNDERFLOW  = 5;
  localparam int ST_LINK_BUFFER     = 4;
  localparam int ST_CMD_OVERFLOW    = 3;
  localparam int ST_MISSING_EOT     = 2;
  localparam int ST_READ_NO_TURN    = 1;
  localparam int ST_ERROR_DETECTED  = 0;

  // Mode config bit positions
  localparam int MODE_HOLD_ERROR    = 4;
  localparam int MODE_NO_EOT_PACKET = 0;

  // Interrupt status bit positions
  localparam int IRQ_ERROR          = 0;
  localparam int IRQ_MISSING_EOT    = 1;
  localparam int IRQ_FIFO_OVERFLOW  = 2;
  localparam int IRQ_FIFO_UNDERFLOW = 3;
  localparam int IRQ_LINK_BUFFER    = 4;
  localparam int IRQ_BITS           = 5;

  // Pixel-stream type window on the low four bits of the type code
  localparam logic [3:0] PIXEL_TYPE_LOW  = 4'hB;
  localparam logic [3:0] PIXEL_TYPE_HIGH = 4'hE;

  // Lane-level error pulses, packed in enable-A bit order
  typedef struct packed {
    logic single_bit_ecc;
    logic lp1_contention;
    logic lp0_contention;
    logic lp_sync;
    logic hs_timeout;
    logic escape_entry;
    logic sot_sync;
    logic sot;
  } phy_errors_t;

  // Protocol error pulses from the packet decoder
  typedef struct packed {
    logic eot_sync;
    logic protocol;
    logic invalid_length;
    logic invalid_type;
    logic multi_bit_ecc;
  } proto_errors_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] channel;
    logic [5:0] packet_type_code;
  } header_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] received;
    logic [15:0] computed;
  } crc_check_t;

  typedef struct packed {
    logic valid;
    logic packet_seen;
  } eot_event_t;

  typedef struct packed {
    logic fifo_overflow;
    logic fifo_underflow;
    logic link_buffer_overflow;
  } buffer_events_t;

endpackage : rx_err_pkg

// ---- host_video_source.sv ----
// Purpose : Behavioural host video source driving receive events
// Assumes : Caller enters send just after a rising edge
// Notes   : Every event lasts exactly one cycle
module host_video_source (
  input  wire logic                   ref_clk,
  output rx_err_pkg::phy_errors_t    phy_errors,
  output rx_err_pkg::proto_errors_t  proto_errors,
  output rx_err_pkg::header_t        header,
  output rx_err_pkg::crc_check_t     crc_check,
  output rx_err_pkg::eot_event_t     eot_event,
  output rx_err_pkg::buffer_events_t buffer_events
);
  timeunit 1ns;
  timeprecision 1ps;
  import rx_err_pkg::*;
  initial begin
    phy_errors    = '0;
    proto_errors  = '0;
    header        = '0;
    crc_check     = '0;
    eot_event     = '0;
    buffer_events = '0;
  end
  // Released packet fields go inverted and error pulses go to zero, so stale packet data is never mistaken for live data
  task automatic send(input phy_errors_t p = '0, input proto_errors_t q = '0,
                      input header_t h = '0, input crc_check_t c = '0,
                      input eot_event_t e = '0, input buffer_events_t b = '0);
    @(posedge ref_clk);
    phy_errors    <= p;
    proto_errors  <= q;
    header        <= h;
    crc_check     <= c;
    eot_event     <= e;
    buffer_events <= b;
    @(posedge ref_clk);
    phy_errors    <= '0;
    proto_errors  <= '0;
    header        <= {1'b0, ~h[7:0]};
    crc_check     <= {1'b0, ~c[31:0]};
    eot_event     <= {1'b0, ~e.packet_seen};
    buffer_events <= '0;
  endtask : send
endmodule : host_video_source

// ---- rx_error_status_checker.sv ----
// Purpose : Concurrent checks on the receive error/status bank ports
// Assumes : Enable-A and hold-error mode values are tracked from completed bus writes
// Notes   : Bound into every rx_error_status instance
module rx_error_status_checker #(
  parameter int COUNT_W = 8
) (
  input wire logic                       ref_clk,
  input wire logic                       sys_rst,
  input wire logic [9:0]                 address,
  input wire logic                       read,
  input wire logic                       write,
  input wire logic [31:0]                writedata,
  input wire logic [31:0]                readdata,
  input wire logic                       waitrequest,
  input wire rx_err_pkg::phy_errors_t    phy_errors,
  input wire rx_err_pkg::proto_errors_t  proto_errors,
  input wire rx_err_pkg::header_t        header,
  input wire rx_err_pkg::crc_check_t     crc_check,
  input wire rx_err_pkg::eot_event_t     eot_event,
  input wire rx_err_pkg::buffer_events_t buffer_events,
  input wire logic                       rx_error,
  input wire logic                       irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import rx_err_pkg::*;
  logic [7:0] en_a;
  logic       hold;
  logic       wr_ok;
  logic       rd_stat;
  logic       quiet;
  assign wr_ok   = write && !waitrequest;
  assign rd_stat = read && !waitrequest && address[9:2] == IDX_STATUS_FLAGS;
  assign quiet   = phy_errors == '0 && proto_errors == '0 && !header.valid && !crc_check.valid;
  // Shadow copies, since the register bodies are out of sight
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      en_a <= RST_ERR_ENABLE_A;
      hold <= 1'b0;
    end else if (wr_ok && address[9:2] == IDX_ERR_ENABLE_A) begin
      en_a <= writedata[7:0];
    end else if (wr_ok && address[9:2] == IDX_MODE_CONFIG) begin
      hold <= writedata[MODE_HOLD_ERROR];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_one_wait;
    waitrequest ##1 !waitrequest;
  endsequence
  a_wait_one: assert property ($rose(read || write) |-> s_one_wait)
    else $error("access wait not one cycle");
  a_wait_idle: assert property (!(read || write) |-> !waitrequest)
    else $error("wait without access");
  a_rd_upper: assert property (read && !waitrequest |-> readdata[31:8] == '0)
    else $error("upper read bits set");
  a_rd_stable: assert property (!read |=> $stable(readdata))
    else $error("read data moved while idle");
  a_err_pulse: assert property (!hold && (phy_errors & en_a) != '0 |=> rx_error)
    else $error("enabled error not shown");
  a_err_quiet: assert property (!hold && quiet |=> !rx_error)
    else $error("error shown without cause");
  a_err_hold: assert property (hold && rx_error && !rd_stat |=> rx_error)
    else $error("held error dropped");
  a_err_cause: assert property ($rose(rx_error) |-> $past(!quiet))
    else $error("error rose without event");
  a_irq_keep: assert property (irq && !wr_ok && !$past(wr_ok) |=> irq)
    else $error("interrupt dropped without write");
endmodule : rx_error_status_checker
bind rx_error_status rx_error_status_checker #(.COUNT_W(COUNT_W)) chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .phy_errors(phy_errors), .proto_errors(proto_errors), .header(header),
  .crc_check(crc_check), .eot_event(eot_event), .buffer_events(buffer_events),
  .rx_error(rx_error), .irq(irq));

// ---- serial_video_rx_error_status_bench.sv ----
// Purpose : Self-checking bench for the receive error/status bank
// Assumes : Events one cycle long; every bus wait is bounded by a timeout
// Notes   : Bus results are taken at the rising edge that sees waitrequest low
module serial_video_rx_error_status_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import rx_err_pkg::*;
  logic           ref_clk = 1'b0;
  logic           sys_rst;
  logic [9:0]     address;
  logic           read;
  logic           write;
  logic [31:0]    writedata;
  logic [31:0]    readdata;
  logic           waitrequest;
  logic           rx_error;
  logic           irq;
  logic [31:0]    rd;
  phy_errors_t    phy_errors;
  proto_errors_t  proto_errors;
  header_t        header;
  crc_check_t     crc_check;
  eot_event_t     eot_event;
  buffer_events_t buffer_events;
  int             err_count = 0;
  int             cmp_count = 0;
  always #4 ref_clk = ~ref_clk;
  rx_error_status uut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .phy_errors(phy_errors), .proto_errors(proto_errors), .header(header),
    .crc_check(crc_check), .eot_event(eot_event), .buffer_events(buffer_events),
    .rx_error(rx_error), .irq(irq));
  host_video_source src (
    .ref_clk(ref_clk), .phy_errors(phy_errors), .proto_errors(proto_errors),
    .header(header), .crc_check(crc_check), .eot_event(eot_event),
    .buffer_events(buffer_events));
  task automatic stop_test;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] idx, wd);
    int n;
    n = 0;
    @(posedge ref_clk);
    // Ignored byte-lane and upper data bits are driven non-zero on purpose
    address <= {idx, 2'b11};
    writedata <= {24'hA5A5A5, wd};
    read <= ~wr;
    write <= wr;
    // Waitrequest and read data are taken as they stand at the rising edge
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 20) begin
      err_count++;
      $display("MISMATCH t=%0t bus timeout", $time);
      stop_test();
    end
  endtask : bus
  task automatic wr(input logic [7:0] idx, d);
    bus(1'b1, idx, d);
  endtask : wr
  task automatic rchk(input logic [7:0] idx, exp, input string what);
    bus(1'b0, idx, 8'h00);
    chk(rd, {24'h0, exp}, what);
  endtask : rchk
  task automatic flag(input logic exp, input string what);
    @(negedge ref_clk);
    chk({31'h0, rx_error}, {31'h0, exp}, what);
  endtask : flag
  task automatic one_err(input logic [7:0] idx, off, input phy_errors_t p,
                         input proto_errors_t q, input header_t h, input crc_check_t c);
    wr(idx, off);
    src.send(p, q, h, c);
    flag(1'b0, "masked error shown");
    rchk(IDX_STATUS_FLAGS, 8'h00, "masked error flagged");
    wr(idx, 8'hFF);
    src.send(p, q, h, c);
    flag(1'b1, "error not shown");
    rchk(IDX_STATUS_FLAGS, 8'h01, "error flag");
    rchk(IDX_STATUS_FLAGS, 8'h00, "flag kept");
  endtask : one_err
  task automatic t_regs;
    logic [7:0] idx[10] = '{IDX_CHANNEL_CONFIG, IDX_MODE_CONFIG, IDX_ERR_ENABLE_A,
      IDX_ERR_ENABLE_B, IDX_STATUS_FLAGS, IDX_ERROR_COUNT, IDX_LAST_PACKET,
      IDX_ERR_REPORT_A, IDX_IRQ_MASK, 8'h30};
    logic [7:0] rv[10] = '{8'h0F, 8'h00, 8'hFF, 8'h7F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 10; i++) rchk(idx[i], rv[i], "reset value");
    wr(IDX_ERR_ENABLE_B, 8'hFF);
    rchk(IDX_ERR_ENABLE_B, 8'h7F, "reserved bit");
    wr(IDX_LAST_PACKET, 8'hFF);
    rchk(IDX_LAST_PACKET, 8'h00, "capture written");
    wr(8'h30, 8'hFF);
    rchk(8'h30, 8'h00, "unmapped");
    wr(IDX_ERR_ENABLE_A, 8'h5A);
    rchk(IDX_ERR_ENABLE_A, 8'h5A, "enable A");
    $display("test regs done");
  endtask : t_regs
  task automatic t_enables;
    int pos[5] = '{0, 2, 4, 5, 6};
    for (int i = 0; i < 8; i++) one_err(IDX_ERR_ENABLE_A, ~(8'h01 << i), 8'h01 << i, '0, '0, '0);
    for (int i = 0; i < 5; i++) one_err(IDX_ERR_ENABLE_B, ~(8'h01 << pos[i]), '0, 5'h01 << i, '0, '0);
    one_err(IDX_ERR_ENABLE_B, 8'hFD, '0, '0, '0, {1'b1, 16'h1234, 16'h1235});
    src.send(.c({1'b1, 16'h1234, 16'h1234}));
    flag(1'b0, "crc match flagged");
    wr(IDX_CHANNEL_CONFIG, 8'h07);
    one_err(IDX_ERR_ENABLE_B, 8'hF7, '0, '0, {1'b1, 2'd3, 6'h3E}, '0);
    rchk(IDX_LAST_PACKET, 8'hFE, "channel filtered");
    wr(IDX_CHANNEL_CONFIG, 8'h0F);
    $display("test enables done");
  endtask : t_enables
  task automatic t_capture;
    logic [7:0] cap;
    cap = 8'hFE;
    for (int lo = 0; lo < 16; lo++) begin
      src.send(.h({1'b1, lo[1:0], 2'b01, lo[3:0]}));
      if (lo >= 'hB && lo <= 'hE) cap = {lo[1:0], 2'b01, lo[3:0]};
      rchk(IDX_LAST_PACKET, cap, "capture");
    end
    $display("test capture done");
  endtask : t_capture
  task automatic t_status;
    src.send(.b(3'b111));
    rchk(IDX_STATUS_FLAGS, 8'h70, "buffer flags");
    rchk(IDX_STATUS_FLAGS, 8'h00, "flags kept");
    fork
      bus(1'b0, IDX_STATUS_FLAGS, 8'h00);
      begin
        @(posedge ref_clk);
        src.send(.b(3'b100));
      end
    join
    chk(rd, 32'h0, "overflow early");
    rchk(IDX_STATUS_FLAGS, 8'h40, "overflow lost on read");
    src.send(.e(2'b10));
    rchk(IDX_STATUS_FLAGS, 8'h04, "missing end packet");
    src.send(.e(2'b11));
    rchk(IDX_STATUS_FLAGS, 8'h00, "end packet seen");
    wr(IDX_MODE_CONFIG, 8'h01);
    src.send(.e(2'b10));
    rchk(IDX_STATUS_FLAGS, 8'h00, "end check off");
    $display("test status done");
  endtask : t_status
  task automatic t_hold;
    logic [7:0] cnt;
    bus(1'b0, IDX_ERROR_COUNT, 8'h00);
    cnt = rd[7:0] + 8'd3;
    wr(IDX_MODE_CONFIG, 8'h10);
    src.send(.p(8'h01));
    repeat (4) @(negedge ref_clk);
    flag(1'b1, "hold lost");
    rchk(IDX_STATUS_FLAGS, 8'h01, "hold flag");
    flag(1'b0, "hold kept");
    wr(IDX_MODE_CONFIG, 8'h00);
    wr(IDX_IRQ_STATUS, 8'h1F);
    wr(IDX_IRQ_MASK, 8'h01);
    src.send(.p(8'h80));
    src.send(.q(5'h10));
    rchk(IDX_ERROR_COUNT, cnt, "count");
    @(negedge ref_clk);
    chk({31'h0, irq}, 32'h1, "irq");
    wr(IDX_IRQ_MASK, 8'h00);
    repeat (2) @(negedge ref_clk);
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(IDX_IRQ_MASK, 8'h01);
    wr(IDX_IRQ_STATUS, 8'h01);
    repeat (2) @(negedge ref_clk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    rchk(IDX_IRQ_STATUS, 8'h00, "irq status");
    $display("test hold done");
  endtask : t_hold
  initial begin
    sys_rst = 1'b1;
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = '0;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_enables();
    t_capture();
    t_status();
    t_hold();
    stop_test();
  end
endmodule : serial_video_rx_error_status_bench
